// ---- hdl/motion_config_pkg.sv ----
// Package: word layouts, bit positions and constants of the configuration checker
package motion_config_pkg;
   localparam int WORD_W = 16;
   localparam int NUM_WORDS = 10;
   localparam int IDX_W = 4;
   // Word indices
   localparam logic [3:0] W_CONTROL = 4'h0;
   localparam logic [3:0] W_SETUP = 4'h1;
   localparam logic [3:0] W_SPEED_HI = 4'h2;
   localparam logic [3:0] W_SPEED_LO = 4'h3;
   localparam logic [3:0] W_STEPS = 4'h4;
   localparam logic [3:0] W_HOLD_GAIN = 4'h5;
   localparam logic [3:0] W_PULSES = 4'h6;
   localparam logic [3:0] W_REST_PCT = 4'h7;
   localparam logic [3:0] W_RUN_CUR = 4'h8;
   localparam logic [3:0] W_LOOP_GAIN = 4'h9;
   localparam logic [3:0] W_LAST = 4'h9;
   // Control word bits
   localparam int C_MODE = 15;
   localparam int C_STALL = 13;
   localparam int C_RSV12 = 12;
   localparam int C_QUAD = 10;
   localparam int C_RSV9 = 9;
   localparam int C_IN3_LSB = 6;
   localparam int C_IN2_LSB = 3;
   localparam int C_IN1_LSB = 0;
   // Setup word bits
   localparam int S_DRV_EN = 15;
   localparam int S_OUT1_FN = 14;
   localparam int S_OUT1_LOSS = 13;
   localparam int S_OUTPUT1_LOSS_STATE = 12;
   localparam int S_SAVE = 10;
   localparam logic [15:0] S_RSV_MASK = 16'h0bf8;
   // Input function codes
   localparam logic [2:0] FN_GP = 3'h0;
   localparam logic [2:0] FN_QUAD = 3'h7;
   localparam logic [15:0] SPEED_LO_MAX = 16'h03e7;
   localparam logic [15:0] STATUS_PWRUP = 16'h6408;
   localparam logic [15:0] SAVE_OK = 16'haaaa;
   localparam logic [15:0] SAVE_FAIL = 16'heeee;

   typedef struct packed {
      logic active;
      logic ok;
   } save_result_type;
endpackage

// ---- hdl/motion_config_word_checker.sv ----
// Configuration-mode word decode, validity check, echo and flash-save control
//
// Function
// - Setup bit 15 gates driver on old firmware, rising edge enables
// - Output 1 fault output or general bit
// - Output 1 on until configuration accepted
// - Link loss holds or forces Output 1
// - Save rising edge writes only valid data
// - Save result AAAA or EEEE, LED colour
// - After save response ignore all commands
// - Bits 2..0 set input active levels
// - Encoder inputs report active-level bit instead
// - Idle current applied at first move end
// - Words 1-9 echo configuration words
// - Word 0 echoes control or status 6408h
// - Word 0 bit 13 meaning follows bit 15
// - Reject reserved bits, lower speed above 999
// - Reject duplicate input functions
// - Encoder needs quad inputs and pulse count
// - Reject stall detection without encoder
// - Power up unconfigured, no motor, no commands
`timescale 1ns/1ps
`default_nettype none
module motion_config_word_checker #(
   parameter int NUM_WORDS = motion_config_pkg::NUM_WORDS
) (
   // Clock and reset
   input  wire logic                   ref_clk,
   input  wire logic                   reset,
   // Network output data from host
   input  wire logic                   outValid,
   input  wire logic [NUM_WORDS*16-1:0] outWords,
   input  wire logic                   linkLost,
   input  wire logic                   gpOutBit,
   input  wire logic                   faultActive,
   input  wire logic                   newFirmware,
   input  wire logic                   moveDone,
   // Raw input pins
   input  wire logic [2:0]             inputPins,
   // Flash write sequencer
   output logic                        flashReq,
   input  wire logic                   flashDone,
   input  wire logic                   flashOk,
   // Network input data to host
   output logic [NUM_WORDS*16-1:0]     inWords,
   // Device controls
   output logic                        output1,
   output logic                        driverOn,
   output logic                        ledGreen,
   output logic                        ledRed,
   output logic                        cmdAccept,
   output logic [2:0]                  inputState,
   output logic [15:0]                 restCurrent
);
   logic [2:0] pinMeta_reg;
   logic [2:0] pinSync_reg;
   logic [15:0] ctl;
   logic [15:0] setup;
   logic [2:0] fn1;
   logic [2:0] fn2;
   logic [2:0] fn3;
   logic encUsed;
   logic dupFn;
   logic cfgValid;
   logic configured_reg;
   logic cfgMode_reg;
   logic prevSave_reg;
   logic prevDrv_reg;
   logic locked_reg;
   logic [15:0] setup_reg;
   logic [15:0] pendRest_reg;
   logic restPend_reg;
   motion_config_pkg::save_result_type result_reg;
   logic saveRise;

   always_comb begin
      ctl = outWords[16*motion_config_pkg::W_CONTROL +: 16];
      setup = outWords[16*motion_config_pkg::W_SETUP +: 16];
      fn1 = ctl[motion_config_pkg::C_IN1_LSB +: 3];
      fn2 = ctl[motion_config_pkg::C_IN2_LSB +: 3];
      fn3 = ctl[motion_config_pkg::C_IN3_LSB +: 3];
      encUsed = ctl[motion_config_pkg::C_QUAD];
   end

   // Duplicate functions, general purpose may repeat; quadrature pair is legal
   always_comb begin
      dupFn = 1'b0;
      if (fn1 == fn2 && fn1 != motion_config_pkg::FN_GP && fn1 != motion_config_pkg::FN_QUAD)
         dupFn = 1'b1;
      if (fn1 == fn3 && fn1 != motion_config_pkg::FN_GP)
         dupFn = 1'b1;
      if (fn2 == fn3 && fn2 != motion_config_pkg::FN_GP)
         dupFn = 1'b1;
   end

   always_comb begin
      cfgValid = 1'b1;
      if ((setup & motion_config_pkg::S_RSV_MASK) != 16'h0000)
         cfgValid = 1'b0;
      if (ctl[motion_config_pkg::C_RSV12] || ctl[motion_config_pkg::C_RSV9])
         cfgValid = 1'b0;
      if (outWords[16*motion_config_pkg::W_SPEED_LO +: 16] > motion_config_pkg::SPEED_LO_MAX)
         cfgValid = 1'b0;
      if (dupFn)
         cfgValid = 1'b0;
      if (fn3 == motion_config_pkg::FN_QUAD)
         cfgValid = 1'b0;
      if ((fn1 == motion_config_pkg::FN_QUAD) != (fn2 == motion_config_pkg::FN_QUAD))
         cfgValid = 1'b0;
      if (encUsed && (fn1 != motion_config_pkg::FN_QUAD || fn2 != motion_config_pkg::FN_QUAD))
         cfgValid = 1'b0;
      if (encUsed && outWords[16*motion_config_pkg::W_PULSES +: 16] == 16'h0000)
         cfgValid = 1'b0;
      if (ctl[motion_config_pkg::C_STALL] && !encUsed)
         cfgValid = 1'b0;
   end

   assign saveRise = outValid && setup[motion_config_pkg::S_SAVE] && !prevSave_reg;

   // Pins come from outside the clock domain
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         pinMeta_reg <= 3'h0;
         pinSync_reg <= 3'h0;
      end else begin
         pinMeta_reg <= inputPins;
         pinSync_reg <= pinMeta_reg;
      end
   end

   // Acceptance of a written configuration
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         configured_reg <= 1'b0;
         cfgMode_reg <= 1'b0;
         setup_reg <= 16'h0000;
         prevSave_reg <= 1'b0;
      end else if (outValid && !locked_reg) begin
         prevSave_reg <= setup[motion_config_pkg::S_SAVE];
         cfgMode_reg <= ctl[motion_config_pkg::C_MODE];
         if (ctl[motion_config_pkg::C_MODE]) begin
            configured_reg <= cfgValid;
            if (cfgValid)
               setup_reg <= setup;
         end
      end
   end

   // Echo words, word 0 follows acceptance in the same cycle
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         inWords <= '0;
         inWords[15:0] <= motion_config_pkg::STATUS_PWRUP;
      end else if (!locked_reg) begin
         if (outValid && ctl[motion_config_pkg::C_MODE]) begin
            inWords[NUM_WORDS*16-1:16] <= outWords[NUM_WORDS*16-1:16];
            if (cfgValid)
               inWords[15:0] <= ctl;
            else
               inWords[15:0] <= motion_config_pkg::STATUS_PWRUP;
         end
         // Save code is assigned last so a write in the result cycle cannot hide it
         if (result_reg.active) begin
            inWords[16*motion_config_pkg::W_LAST +: 16] <=
               result_reg.ok ? motion_config_pkg::SAVE_OK : motion_config_pkg::SAVE_FAIL;
         end
      end
   end

   // Flash save handshake; lock on the same edge that writes the response
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         flashReq <= 1'b0;
         result_reg <= '0;
         locked_reg <= 1'b0;
      end else begin
         if (saveRise && cfgValid && ctl[motion_config_pkg::C_MODE] && !locked_reg
             && !flashReq && !result_reg.active)
            flashReq <= 1'b1;
         else if (flashReq && flashDone) begin
            flashReq <= 1'b0;
            result_reg.active <= 1'b1;
            result_reg.ok <= flashOk;
         end
         if (result_reg.active)
            locked_reg <= 1'b1;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         ledGreen <= 1'b0;
         ledRed <= 1'b0;
      end else if (result_reg.active) begin
         ledGreen <= result_reg.ok;
         ledRed <= !result_reg.ok;
      end
   end

   // Driver enable, rising edge needed on old firmware
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         driverOn <= 1'b0;
         prevDrv_reg <= 1'b0;
      end else if (outValid && !locked_reg && ctl[motion_config_pkg::C_MODE]) begin
         prevDrv_reg <= setup[motion_config_pkg::S_DRV_EN];
         if (newFirmware)
            driverOn <= cfgValid || configured_reg;
         else if (!setup[motion_config_pkg::S_DRV_EN])
            driverOn <= 1'b0;
         else if (!prevDrv_reg && cfgValid)
            driverOn <= 1'b1;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset)
         cmdAccept <= 1'b0;
      else
         cmdAccept <= configured_reg && !cfgMode_reg && !locked_reg;
   end

   // Output 1 source
   always_ff @(posedge ref_clk) begin
      if (reset)
         output1 <= 1'b1;
      else if (!configured_reg)
         output1 <= 1'b1;
      else if (linkLost) begin
         if (setup_reg[motion_config_pkg::S_OUT1_LOSS])
            output1 <= setup_reg[motion_config_pkg::S_OUTPUT1_LOSS_STATE];
      end else if (setup_reg[motion_config_pkg::S_OUT1_FN])
         output1 <= gpOutBit;
      else
         output1 <= !faultActive;
   end

   // Active level and encoder substitution per input
   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++) begin : g_in
         always_ff @(posedge ref_clk) begin
            if (reset)
               inputState[gi] <= 1'b0;
            else if (encUsed && gi < 2)
               inputState[gi] <= setup_reg[gi];
            else
               inputState[gi] <= !(pinSync_reg[gi] ^ setup_reg[gi]);
         end
      end
   endgenerate

   // Idle current waits for the end of the next move
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         restCurrent <= 16'h0000;
         pendRest_reg <= 16'h0000;
         restPend_reg <= 1'b0;
      end else if (outValid && !locked_reg && ctl[motion_config_pkg::C_MODE] && cfgValid) begin
         pendRest_reg <= outWords[16*motion_config_pkg::W_REST_PCT +: 16];
         restPend_reg <= 1'b1;
      end else if (restPend_reg && moveDone) begin
         restCurrent <= pendRest_reg;
         restPend_reg <= 1'b0;
      end
   end

   // Word 0 and echo
   chk_invalid_status: assert property (@(posedge ref_clk) disable iff (reset)
      outValid && !locked_reg && ctl[motion_config_pkg::C_MODE] && !cfgValid
      |=> inWords[15:0] == motion_config_pkg::STATUS_PWRUP)
      else $error("word 0 not status on invalid config");
   chk_valid_echo: assert property (@(posedge ref_clk) disable iff (reset)
      outValid && !locked_reg && ctl[motion_config_pkg::C_MODE] && cfgValid
      |=> inWords[15:0] == $past(ctl))
      else $error("word 0 not echo");
   chk_locked_frozen: assert property (@(posedge ref_clk) disable iff (reset)
      locked_reg |=> $stable(inWords))
      else $error("input words changed after save");

   // Validity
   chk_reserved_reject: assert property (@(posedge ref_clk) disable iff (reset)
      (setup & motion_config_pkg::S_RSV_MASK) != 16'h0000 |-> !cfgValid)
      else $error("reserved setup bit accepted");
   chk_speed_reject: assert property (@(posedge ref_clk) disable iff (reset)
      outWords[16*motion_config_pkg::W_SPEED_LO +: 16] > motion_config_pkg::SPEED_LO_MAX
      |-> !cfgValid)
      else $error("lower speed above limit accepted");
   chk_dup_reject: assert property (@(posedge ref_clk) disable iff (reset)
      dupFn |-> !cfgValid)
      else $error("duplicate input function accepted");
   chk_stall_noenc: assert property (@(posedge ref_clk) disable iff (reset)
      ctl[motion_config_pkg::C_STALL] && !ctl[motion_config_pkg::C_QUAD] |-> !cfgValid)
      else $error("stall without encoder accepted");

   // Flash save
   chk_save_invalid: assert property (@(posedge ref_clk) disable iff (reset)
      saveRise && !cfgValid && !flashReq |=> !flashReq)
      else $error("save on invalid data");
   chk_req_hold: assert property (@(posedge ref_clk) disable iff (reset)
      flashReq && !flashDone |=> flashReq)
      else $error("save request dropped early");
   chk_save_code: assert property (@(posedge ref_clk) disable iff (reset)
      flashReq && flashDone |-> ##2
      inWords[16*motion_config_pkg::W_LAST +: 16] ==
      ($past(flashOk, 2) ? motion_config_pkg::SAVE_OK : motion_config_pkg::SAVE_FAIL))
      else $error("save result wrong");
   chk_lock_hold: assert property (@(posedge ref_clk) disable iff (reset)
      locked_reg |=> locked_reg && !flashReq && !cmdAccept)
      else $error("commands after save");

   // Commands and driver
   chk_no_cmd_unconf: assert property (@(posedge ref_clk) disable iff (reset)
      !configured_reg |=> !cmdAccept)
      else $error("commands accepted while unconfigured");
   chk_drive_cfg: assert property (@(posedge ref_clk) disable iff (reset)
      $rose(driverOn) |-> $past(outValid) && $past(cfgValid || configured_reg))
      else $error("driver powered without configuration");

   // Output 1
   chk_out1_unconf: assert property (@(posedge ref_clk) disable iff (reset)
      !configured_reg |=> output1)
      else $error("output1 off while unconfigured");
   chk_fault_out: assert property (@(posedge ref_clk) disable iff (reset)
      configured_reg && !linkLost && !setup_reg[motion_config_pkg::S_OUT1_FN]
      |=> output1 == !$past(faultActive))
      else $error("output1 not fault output");
   chk_gp_out: assert property (@(posedge ref_clk) disable iff (reset)
      configured_reg && !linkLost && setup_reg[motion_config_pkg::S_OUT1_FN]
      |=> output1 == $past(gpOutBit))
      else $error("output1 not general bit");
   chk_loss_force: assert property (@(posedge ref_clk) disable iff (reset)
      configured_reg && linkLost && setup_reg[motion_config_pkg::S_OUT1_LOSS]
      |=> output1 == $past(setup_reg[motion_config_pkg::S_OUTPUT1_LOSS_STATE]))
      else $error("loss state not applied");
   chk_loss_hold: assert property (@(posedge ref_clk) disable iff (reset)
      configured_reg && linkLost && !setup_reg[motion_config_pkg::S_OUT1_LOSS]
      |=> $stable(output1))
      else $error("output1 not held on link loss");

   // Inputs and idle current
   chk_enc_report: assert property (@(posedge ref_clk) disable iff (reset)
      encUsed |=> inputState[0] == $past(setup_reg[0]))
      else $error("encoder input state reported");
   chk_rest_wait: assert property (@(posedge ref_clk) disable iff (reset)
      !(restPend_reg && moveDone) |=> $stable(restCurrent))
      else $error("idle current applied before move end");

   cov_accept: cover property (@(posedge ref_clk) outValid && ctl[motion_config_pkg::C_MODE] && cfgValid);
   cov_save_ok: cover property (@(posedge ref_clk) flashReq && flashDone && flashOk);
   cov_save_fail: cover property (@(posedge ref_clk) flashReq && flashDone && !flashOk);
   cov_link_loss: cover property (@(posedge ref_clk) configured_reg && linkLost);
   cov_locked_write: cover property (@(posedge ref_clk) locked_reg && outValid);
endmodule
`default_nettype wire

// ---- verification/flash_seq_model.sv ----
// Flash write sequencer model answering the save handshake
`timescale 1ns/1ps
`default_nettype none
module flash_seq_model (
   // Clock and reset
   input  wire logic       ref_clk,
   input  wire logic       reset,
   // Save handshake
   input  wire logic       flashReq,
   input  wire logic [3:0] lag,
   input  wire logic       passSel,
   output logic            flashDone,
   output logic            flashOk
);
   logic [3:0] cnt;

   // Result toggles outside its valid cycle so a stale value is never trusted
   always @(posedge ref_clk) begin
      flashDone <= 1'b0;
      flashOk <= ~flashOk;
      if (reset) begin
         cnt <= 4'h0;
         flashOk <= 1'b0;
      end else if (flashReq && !flashDone) begin
         cnt <= cnt + 4'h1;
         if (cnt == lag) begin
            flashDone <= 1'b1;
            flashOk <= passSel;
            cnt <= 4'h0;
         end
      end
   end
endmodule
`default_nettype wire

// ---- verification/testbench.sv ----
// Self-checking testbench of the configuration word checker
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic ref_clk = 1'b0, reset = 1'b1, outValid = 1'b0, linkLost = 1'b0;
   logic gpOutBit = 1'b0, faultActive = 1'b0, newFirmware = 1'b0, moveDone = 1'b0;
   logic [159:0] outWords = '0, inWords;
   logic [2:0]   inputPins = 3'h0, inputState;
   logic         flashReq, flashDone, flashOk, output1, driverOn, ledGreen, ledRed, cmdAccept;
   logic [15:0]  restCurrent, w [10];
   logic [31:0]  seed = 32'h1c3d6f48;
   logic [3:0]   lag = 4'hf;
   logic         passSel = 1'b1;
   int           miscompares = 0, n_checks = 0, cyc = 0;

   always #2 ref_clk = ~ref_clk;

   motion_config_word_checker uut (.ref_clk, .reset, .outValid, .outWords, .linkLost, .gpOutBit,
      .faultActive, .newFirmware, .moveDone, .inputPins, .flashReq, .flashDone, .flashOk,
      .inWords, .output1, .driverOn, .ledGreen, .ledRed, .cmdAccept, .inputState, .restCurrent);
   flash_seq_model partner (.ref_clk, .reset, .flashReq, .lag, .passSel, .flashDone, .flashOk);

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic logic [2:0] active(input logic [2:0] pins, input logic [2:0] lvl);
      return ~(pins ^ lvl);
   endfunction
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      n_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic send();
      @(negedge ref_clk);
      for (int k = 0; k < 10; k++) outWords[16*k +: 16] = w[k];
      outValid = 1'b1;
      @(negedge ref_clk);
      outValid = 1'b0;
      repeat (4) @(negedge ref_clk);
   endtask
   task automatic mkvalid();
      for (int k = 0; k < 10; k++) begin
         seed = lfsr(seed);
         w[k] = seed[15:0];
      end
      // Encoder pair on inputs 1 and 2, stall on, input 3 any other code
      w[0] = {7'h52, (w[0][2:0] == 3'h7) ? 3'h0 : w[0][2:0], 6'h3f};
      w[1] = w[1] & 16'hf007;
      w[3] = w[3] % 16'd1000;
      w[6] = w[6] | 16'h0001;
   endtask
   task automatic do_reset();
      @(negedge ref_clk);
      reset = 1'b1;
      repeat (10) @(negedge ref_clk);
      reset = 1'b0;
   endtask
   task automatic save(input logic ok, input logic [15:0] code);
      passSel = ok;
      // Bit 10 must be seen low first, or no save edge follows
      w[1] = 16'h8005;
      send();
      w[1] = 16'h8405;
      send();
      if (lag == 4'hf)
         chk("flashReq", 16'h1, {15'h0, flashReq});
      for (int t = 0; t < 60 && !(ledGreen | ledRed); t++) @(negedge ref_clk);
      @(negedge ref_clk);
      chk("saveCode", code, inWords[159:144]);
      chk("led", {14'h0, ok, ~ok}, {14'h0, ledGreen, ledRed});
   endtask

   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 20000) begin
         miscompares++;
         wrap_up();
      end
   end

   initial begin
      do_reset();
      chk("word0", 16'h6408, inWords[15:0]);
      chk("output1", 16'h1, {15'h0, output1});
      chk("driverOn", 16'h0, {15'h0, driverOn});
      for (int i = 0; i < 7; i++) begin
         mkvalid();
         if (i == 0)
            w[3] = 16'd999;
         send();
         for (int k = 0; k < 10; k++) chk("echo", w[k], inWords[16*k +: 16]);
         chk("encIn", {14'h0, w[1][1:0]}, {14'h0, inputState[1:0]});
         case (i)
            0: w[1] = w[1] | 16'h0800;
            1: w[1] = w[1] | 16'h0008;
            2: w[3] = 16'd1000;
            3: w[0] = 16'h8009;
            4: w[0] = 16'h8407;
            5: w[6] = 16'h0000;
            default: w[0] = 16'ha011;
         endcase
         send();
         chk("reject", 16'h6408, inWords[15:0]);
      end
      w[0] = 16'h80d1;
      w[1] = 16'h0005;
      w[7] = 16'h0032;
      inputPins = 3'b011;
      faultActive = 1'b1;
      send();
      chk("inputs", {13'h0, active(3'b011, 3'b101)}, {13'h0, inputState});
      chk("output1", 16'h0, {15'h0, output1});
      chk("driverOn", 16'h0, {15'h0, driverOn});
      chk("restCur", 16'h0, restCurrent);
      faultActive = 1'b0;
      moveDone = 1'b1;
      @(negedge ref_clk);
      moveDone = 1'b0;
      repeat (2) @(negedge ref_clk);
      chk("output1", 16'h1, {15'h0, output1});
      chk("restCur", 16'h0032, restCurrent);
      gpOutBit = 1'b1;
      w[1] = 16'he005;
      send();
      chk("driverOn", 16'h1, {15'h0, driverOn});
      chk("output1", 16'h1, {15'h0, output1});
      linkLost = 1'b1;
      repeat (3) @(negedge ref_clk);
      chk("output1", 16'h0, {15'h0, output1});
      linkLost = 1'b0;
      w[0] = 16'h0000;
      send();
      chk("cmdAccept", 16'h1, {15'h0, cmdAccept});
      w[0] = 16'h80d1;
      w[1] = 16'h0c05;
      send();
      chk("flashReq", 16'h0, {15'h0, flashReq});
      save(1'b1, motion_config_pkg::SAVE_OK);
      w[1] = 16'h8001;
      send();
      chk("locked", 16'h8405, inWords[31:16]);
      chk("cmdAccept", 16'h0, {15'h0, cmdAccept});
      do_reset();
      chk("word0", 16'h6408, inWords[15:0]);
      newFirmware = 1'b1;
      w[1] = 16'h0005;
      send();
      chk("driverOn", 16'h1, {15'h0, driverOn});
      lag = 4'h0;
      save(1'b0, motion_config_pkg::SAVE_FAIL);
      wrap_up();
   end
endmodule
`default_nettype wire
